// [twi_reg_slave.sv]
// two-wire slave port giving an outside master byte access to a register bank
// assumes the bank lives on clk and answers rd_data for the current pointer
// How it works
// - answer address 1001 plus three select pins
// - serial clock is input only, never driven
// - data changes only while clock low
// - pointer held until reset or replaced
// - repeated start, read address acknowledged
// - shift out pointed register, master acknowledges
// - write byte stored and acknowledged
`timescale 1ns/10ps
module twi_reg_slave
  import twi_slave_pkg::*;
(
  // core clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // link clock and its reset
  input wire logic link_clk,
  input wire logic link_rst,
  // straps
  input wire logic mode_serial,
  input wire logic [2:0] addr_sel,
  // bus pins, scl is input only
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // register bank side, on clk
  output logic [BYTE_W-1:0] reg_ptr,
  output logic reg_wr_strobe,
  output logic [BYTE_W-1:0] reg_wr_data,
  input wire logic [BYTE_W-1:0] rd_data
);

  // ----------------------------------------------------------------
  // link domain
  // ----------------------------------------------------------------
  line_ev_t ev;

  twi_line_sense u_sense (
    .link_clk(link_clk),
    .link_rst(link_rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ev(ev)
  );

  typedef struct packed {
    phase_t phase;
    logic [CNT_W-1:0] bit_cnt;
    logic [BYTE_W-1:0] shift;
    logic is_read;
    logic ack_now;
    logic drive_low;
    logic [BYTE_W-1:0] ptr;
    logic ptr_tgl;
    logic [BYTE_W-1:0] wdata;
    logic wr_tgl;
    logic [1:0] mode_sync;
    logic [2:0] addr_q;
    logic [BYTE_W-1:0] rd_cap;
    logic [2:0] addr_pin;
    logic oe_n;
    logic sda_lvl;
  } link_st_t;

  link_st_t l;
  link_st_t next_l;
  logic [BYTE_W-1:0] rd_hold;

  always_comb begin
    next_l = l;
    next_l.mode_sync = {l.mode_sync[0], mode_serial};
    next_l.addr_pin = addr_sel;
    next_l.rd_cap = rd_hold;
    if (ev.stop || !l.mode_sync[1]) begin
      // stop or pin-control mode releases the bus
      next_l.phase = ST_IDLE;
      next_l.drive_low = 1'b0;
      next_l.ack_now = 1'b0;
    end else if (ev.start) begin
      // start and repeated start both restart address capture
      next_l.phase = ST_ADDR;
      next_l.bit_cnt = '0;
      next_l.drive_low = 1'b0;
      next_l.ack_now = 1'b0;
      next_l.addr_q = l.addr_pin;
    end else if (ev.rise && l.phase != ST_IDLE && !l.ack_now) begin
      // shift in msb first on rising clock
      next_l.shift = {l.shift[BYTE_W-2:0], ev.sda};
      next_l.bit_cnt = l.bit_cnt + 4'h1;
      if (l.phase == ST_WAITMACK && l.bit_cnt == '0) begin
        // one byte per read; bus left free for stop or restart
        next_l.phase = ST_IDLE;
        next_l.bit_cnt = '0;
      end
    end else if (ev.fall && (l.phase != ST_IDLE || l.ack_now)) begin
      // outputs move only after falling clock
      next_l.drive_low = 1'b0;
      if (l.ack_now) begin
        next_l.ack_now = 1'b0;
        next_l.bit_cnt = '0;
        if (l.phase == ST_RDATA) begin
          next_l.drive_low = ~l.shift[BYTE_W-1];
        end
      end else if (l.phase == ST_RDATA) begin
        if (l.bit_cnt == ACK_SLOT) begin
          next_l.phase = ST_WAITMACK;
          next_l.bit_cnt = '0;
        end else begin
          // read data out msb first, rising clock already shifted
          next_l.drive_low = ~l.shift[BYTE_W-1];
        end
      end else if (l.bit_cnt == ACK_SLOT && l.phase != ST_WAITMACK) begin
        unique case (l.phase)
          ST_ADDR: begin
            // own address only: fixed high nibble plus pins
            if (l.shift[BYTE_W-1:1] == {ADDR_FIXED_HI, l.addr_q}) begin
              next_l.ack_now = 1'b1;
              next_l.drive_low = 1'b1;
              next_l.is_read = l.shift[0];
              // read address acknowledged, then data follows
              next_l.phase = l.shift[0] ? ST_RDATA : ST_PTR;
              next_l.shift = l.rd_cap;
            end else begin
              next_l.phase = ST_IDLE;
            end
          end
          ST_PTR: begin
            // pointer kept until replaced
            next_l.ptr = l.shift;
            next_l.ptr_tgl = ~l.ptr_tgl;
            next_l.ack_now = 1'b1;
            next_l.drive_low = 1'b1;
            next_l.phase = ST_WDATA;
          end
          ST_WDATA: begin
            // write data stored and acknowledged
            next_l.wdata = l.shift;
            next_l.wr_tgl = ~l.wr_tgl;
            next_l.ack_now = 1'b1;
            next_l.drive_low = 1'b1;
            next_l.phase = ST_IDLE;
          end
          default: begin
            next_l.phase = ST_IDLE;
          end
        endcase
      end
    end
    next_l.oe_n = ~next_l.drive_low;
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      l <= '{phase: ST_IDLE, bit_cnt: '0, shift: '0, is_read: 1'b0, ack_now: 1'b0,
             drive_low: 1'b0, ptr: PTR_RESET, ptr_tgl: 1'b0, wdata: '0,
             wr_tgl: 1'b0, mode_sync: 2'h0, addr_q: 3'h0, rd_cap: '0, addr_pin: 3'h0,
             oe_n: 1'b1, sda_lvl: 1'b0};
    end else begin
      l <= next_l;
    end
  end

  // open drain: only ever pull sda low, scl is never driven
  assign sda_out = l.sda_lvl;
  assign sda_oe_n = l.oe_n;

  // ----------------------------------------------------------------
  // core domain
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] ptr_sync;
    logic [2:0] wr_sync;
    logic [BYTE_W-1:0] ptr;
    reg_wr_t wr;
    logic [BYTE_W-1:0] rd_hold;
  } core_st_t;

  core_st_t c;
  core_st_t next_c;

  always_comb begin
    next_c = c;
    next_c.ptr_sync = {c.ptr_sync[1:0], l.ptr_tgl};
    next_c.wr_sync = {c.wr_sync[1:0], l.wr_tgl};
    next_c.wr.strobe = 1'b0;
    // pointer word is stable long before its toggle arrives
    if (c.ptr_sync[2] != c.ptr_sync[1]) begin
      next_c.ptr = l.ptr;
    end
    if (c.wr_sync[2] != c.wr_sync[1]) begin
      next_c.wr.strobe = 1'b1;
      next_c.wr.ptr = c.ptr;
      next_c.wr.data = l.wdata;
    end
    next_c.rd_hold = rd_data;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      c <= '{ptr_sync: 3'h0, wr_sync: 3'h0, ptr: PTR_RESET, wr: '0, rd_hold: '0};
    end else begin
      c <= next_c;
    end
  end

  // read byte is quasi-static; link side recaptures it every cycle
  assign rd_hold = c.rd_hold;
  assign reg_ptr = c.ptr;
  assign reg_wr_strobe = c.wr.strobe;
  assign reg_wr_data = c.wr.data;

endmodule

// [twi_slave_pkg.sv]
// package for the two-wire register access slave
// shared by the slave core and its bit-capture module
package twi_slave_pkg;

  localparam int ADDR_W = 7;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 4;
  localparam logic [3:0] ADDR_FIXED_HI = 4'h9;
  localparam logic [CNT_W-1:0] LAST_BIT = 4'h7;
  localparam logic [CNT_W-1:0] ACK_SLOT = 4'h8;
  localparam logic [BYTE_W-1:0] PTR_RESET = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_PTR,
    ST_WDATA,
    ST_RDATA,
    ST_WAITMACK
  } phase_t;

  // line events seen in the link domain
  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic sda;
  } line_ev_t;

  // write request to the register bank
  typedef struct packed {
    logic strobe;
    logic [BYTE_W-1:0] ptr;
    logic [BYTE_W-1:0] data;
  } reg_wr_t;

endpackage

// [twi_line_sense.sv]
// line sensing: two-flop synchronisers on scl and sda, then edge and
// start/stop detection; assumes scl and sda are pin levels from outside
`timescale 1ns/10ps
module twi_line_sense
  import twi_slave_pkg::*;
(
  // link clock and reset
  input wire logic link_clk,
  input wire logic link_rst,
  // pins
  input wire logic scl_in,
  input wire logic sda_in,
  // events
  output line_ev_t ev
);

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_q;
    logic sda_q;
    line_ev_t ev;
  } sense_t;

  sense_t s;
  sense_t next_s;

  always_comb begin
    next_s = s;
    next_s.scl_sync = {s.scl_sync[0], scl_in};
    next_s.sda_sync = {s.sda_sync[0], sda_in};
    next_s.scl_q = s.scl_sync[1];
    next_s.sda_q = s.sda_sync[1];
    // data sampled on rising scl, driven after falling scl
    next_s.ev.rise = s.scl_sync[1] & ~s.scl_q;
    next_s.ev.fall = ~s.scl_sync[1] & s.scl_q;
    // sda moving while scl high marks start or stop
    next_s.ev.start = s.scl_sync[1] & s.scl_q & s.sda_q & ~s.sda_sync[1];
    next_s.ev.stop = s.scl_sync[1] & s.scl_q & ~s.sda_q & s.sda_sync[1];
    next_s.ev.sda = s.sda_sync[1];
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      s <= '{scl_sync: 2'h3, sda_sync: 2'h3, scl_q: 1'b1, sda_q: 1'b1, ev: '0};
    end else begin
      s <= next_s;
    end
  end

  assign ev = s.ev;

endmodule

// [twi_reg_chk.sv]
// assertions on the two-wire slave port
// bound to twi_reg_slave, sees its ports only
`timescale 1ns/10ps
module twi_reg_chk
  import twi_slave_pkg::*;
(
  // clocks and resets
  input logic clk,
  input logic sys_rst,
  input logic link_clk,
  input logic link_rst,
  // pins and bank
  input logic mode_serial,
  input logic scl_in,
  input logic sda_out,
  input logic sda_oe_n,
  input logic [BYTE_W-1:0] reg_ptr,
  input logic reg_wr_strobe
);
  sequence s_pin_mode;
    !mode_serial [*8];
  endsequence
  chk_ptr_reset: assert property (@(posedge clk)
    sys_rst |=> reg_ptr == PTR_RESET) else $error("ptr reset");
  chk_wr_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    reg_wr_strobe |=> !reg_wr_strobe) else $error("strobe width");
  chk_ptr_hold: assert property (@(posedge clk) disable iff (sys_rst)
    reg_wr_strobe |=> $stable(reg_ptr)) else $error("ptr moved");
  chk_wr_acked: assert property (@(posedge clk) disable iff (sys_rst)
    reg_wr_strobe |-> !sda_oe_n) else $error("no ack");
  chk_drive_low: assert property (@(posedge link_clk) disable iff (link_rst)
    !sda_oe_n |-> !sda_out && $past(mode_serial, 3)) else $error("sda driven");
  chk_scl_low: assert property (@(posedge link_clk) disable iff (link_rst)
    $changed(sda_oe_n) |-> !scl_in) else $error("sda moved");
  chk_low_held: assert property (@(posedge link_clk) disable iff (link_rst)
    $fell(sda_oe_n) |-> !sda_oe_n [*8]) else $error("low short");
  chk_pin_mode: assert property (@(posedge link_clk) disable iff (link_rst)
    s_pin_mode |-> sda_oe_n) else $error("pin mode");
endmodule
bind twi_reg_slave twi_reg_chk u_chk (.clk, .sys_rst, .link_clk, .link_rst,
  .mode_serial, .scl_in, .sda_out, .sda_oe_n, .reg_ptr, .reg_wr_strobe);

// [twi_master_model.sv]
// bus master model for the two-wire slave bench
// sda is open drain with pull-up, read on sda_line
`timescale 1ns/10ps
module twi_master_model (
  // pacing clock
  input logic clk,
  // bus, sda 1 = released
  input logic sda_line,
  output logic scl = 1'b1,
  output logic sda = 1'b1
);
  task automatic walk(input logic [7:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      {sda, scl} = v[2*i+:2];
      repeat (40) @(negedge clk);
    end
  endtask
  task automatic start;
    walk(8'b10_11_01_00, 4);
  endtask
  task automatic stop;
    walk(8'h07, 3);
  endtask
  task automatic bit_io(input logic b, output logic r);
    walk({4'h0, b, 1'b0, b, 1'b1}, 2);
    r = sda_line;
    walk({6'h0, b, 1'b0}, 1);
  endtask
  task automatic send(input logic [7:0] v, output logic r);
    for (int i = 7; i >= 0; i--)
      bit_io(v[i], r);
    bit_io(1'b1, r);
  endtask
  task automatic recv(input logic k, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, v[i]);
    bit_io(k, r);
  endtask
endmodule

// [tb_two_wire_register_access_slave.sv]
// self-checking bench for the two-wire slave port
// a master model drives the bus; rd_data echoes the last write
`timescale 1ns/10ps
module tb_two_wire_register_access_slave
  import twi_slave_pkg::*;
;
  logic clk = 0, link_clk = 0, sys_rst = 1, link_rst = 1, mode_serial = 1, a;
  logic scl_in, sda_m, sda_out, sda_oe_n, reg_wr_strobe;
  logic [2:0] addr_sel = 3'h3;
  logic [7:0] rd_data = 8'h00, reg_ptr, reg_wr_data, d;
  wire sda_in = sda_m & (sda_oe_n | sda_out);
  int n_fail = 0, check_count = 0, cyc = 0;
  always #2 clk = ~clk;
  always #3 link_clk = ~link_clk;
  twi_master_model m (.clk, .sda_line(sda_in), .scl(scl_in), .sda(sda_m));
  twi_reg_slave u_dut (.clk, .sys_rst, .link_clk, .link_rst, .mode_serial, .addr_sel,
    .scl_in, .sda_in, .sda_out, .sda_oe_n, .reg_ptr, .reg_wr_strobe, .reg_wr_data, .rd_data);
  always @(negedge clk) begin
    if (reg_wr_strobe)
      rd_data <= reg_wr_data;
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("%0d checks, %0d failed", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask
  task automatic ack(input logic e);
    chk("ack", {7'h0, e}, {7'h0, a});
  endtask
  task automatic head(input logic [7:0] adr, input logic [7:0] ptr);
    m.start();
    m.send(adr, a);
    ack(1'b0);
    m.send(ptr, a);
    ack(1'b0);
  endtask
  task automatic t_reset;
    {sys_rst, link_rst} = 2'b11;
    repeat (6) @(negedge clk);
    {sys_rst, link_rst} = 2'b00;
    repeat (20) @(negedge clk);
    chk("ptr", PTR_RESET, reg_ptr);
    $display("reset done");
  endtask
  task automatic t_write;
    head(8'h96, 8'h6d);
    m.send(8'h92, a);
    ack(1'b0);
    m.stop();
    chk("wdata", 8'h92, rd_data);
    chk("ptr", 8'h6d, reg_ptr);
    $display("write done");
  endtask
  task automatic t_read;
    head(8'h96, 8'h6d);
    m.start();
    m.send(8'h97, a);
    ack(1'b0);
    m.recv(1'b0, d);
    chk("rdata", 8'h92, d);
    m.start();
    m.send(8'h97, a);
    ack(1'b0);
    m.recv(1'b1, d);
    chk("reread", 8'h92, d);
    m.stop();
    $display("read done");
  endtask
  task automatic t_sel;
    for (int k = 0; k < 8; k++) begin
      addr_sel = k[2:0];
      head({ADDR_FIXED_HI, k[2:0], 1'b0}, {5'h0, k[2:0]});
      m.stop();
      chk("ptr", {5'h0, k[2:0]}, reg_ptr);
    end
    $display("select done");
  endtask
  task automatic t_refuse;
    addr_sel = 3'h3;
    m.start();
    m.send(8'h94, a);
    ack(1'b1);
    m.send(8'h96, a);
    ack(1'b1);
    m.stop();
    chk("ptr", 8'h07, reg_ptr);
    mode_serial = 0;
    m.start();
    m.send(8'h96, a);
    ack(1'b1);
    m.stop();
    mode_serial = 1;
    $display("refusal done");
  endtask
  initial begin
    t_reset();
    t_write();
    t_read();
    t_sel();
    t_refuse();
    t_reset();
    wrap_up();
  end
endmodule
